// ---- rpsc_defs.svh ----
// Purpose: Timing counts and encodings for the remote power-save controller
// Assumes: 40 MHz clock
// Notes: Long counts are defaults of top-level parameters
`ifndef RPSC_DEFS_SVH
`define RPSC_DEFS_SVH
`define RPSC_CLK_HZ 34'h2625a00
`define RPSC_WAKE_TIMER_S 34'h12c
`define RPSC_WAKE_TIMER_CYC (`RPSC_WAKE_TIMER_S * `RPSC_CLK_HZ)
`define RPSC_READY_MS 34'h4b
`define RPSC_MS_PER_S 34'h3e8
`define RPSC_READY_CYC ((`RPSC_READY_MS * `RPSC_CLK_HZ) / `RPSC_MS_PER_S)
`define RPSC_AUTO_SLEEP_CYC 34'h3d0900
`define RPSC_RESYNC_CYC 34'h61a80
// Waking is cut short by the pin synchroniser delay plus slack
`define RPSC_WAKE_MARGIN 34'h8
`define RPSC_CNT_W 34
`define RPSC_ROLE_MASTER 2'h0
`define RPSC_ROLE_REMOTE 2'h1
`define RPSC_ROLE_EXT 2'h2
`define RPSC_AUTO_DOZE_RST 1'h0
`endif

// ---- rpsc_pkg.sv ----
// Purpose: Types for the remote power-save controller
// Assumes: Included definitions header
// Notes: None
package rpsc_pkg;
	typedef enum logic [2:0] {ST_AWAKE, ST_SEARCH, ST_EXT_SLEEP, ST_AUTO_SLEEP, ST_WAKING} rpsc_state_t;
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} rpsc_sync_t;
endpackage

// ---- rpsc_sync_if.sv ----
// Purpose: Carries the raw and filtered sleep control level
// Assumes: Single clock
// Notes: None
`timescale 1ns/1ps
interface rpsc_sync_if;
	logic rawLevel;
	logic level;
	modport src (input rawLevel, output level);
	modport dst (output rawLevel, input level);
endinterface

// ---- rpsc_pin_sync.sv ----
// Purpose: Three-stage synchroniser for the sleep control pin
// Assumes: Level changes slow compared with the clock
// Notes: Level changes once stages two and three agree
`timescale 1ns/1ps
module rpsc_pin_sync (
	input wire logic clock,
	input wire logic rst,
	rpsc_sync_if.src sy
);
	rpsc_pkg::rpsc_sync_t st_reg;
	rpsc_pkg::rpsc_sync_t st_next;
	always_comb begin
		st_next = st_reg;
		st_next.s1 = sy.rawLevel;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (st_reg.s2 == st_reg.s3) begin
			st_next.level = st_reg.s3;
		end
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			st_reg <= '{s1: 1'h1, s2: 1'h1, s3: 1'h1, level: 1'h1};
		end else begin
			st_reg <= st_next;
		end
	end
	assign sy.level = st_reg.level;
	chk_sync_agree: assert property (@(posedge clock) disable iff (rst)
		(st_reg.s2 == st_reg.s3) |=> (st_reg.level == $past(st_reg.s3))) else $error("sync level wrong");
endmodule

// ---- rpsc_top.sv ----
// Purpose: Sleep and automatic doze sequencing for a remote radio unit
// Assumes: 40 MHz clock, synchronous active-high reset
// Notes: Sleep control pin is active low; sleep hides all normal functions
`timescale 1ns/1ps
`include "rpsc_defs.svh"
module rpsc_top #(
	parameter logic [`RPSC_CNT_W-1:0] WAKE_TIMER_CYC = `RPSC_WAKE_TIMER_CYC,
	parameter logic [`RPSC_CNT_W-1:0] READY_CYC = `RPSC_READY_CYC,
	parameter logic [`RPSC_CNT_W-1:0] AUTO_SLEEP_CYC = `RPSC_AUTO_SLEEP_CYC,
	parameter logic [`RPSC_CNT_W-1:0] RESYNC_CYC = `RPSC_RESYNC_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] unitRole,
	input wire logic dozeEnable,
	input wire logic sleepCtlN,
	input wire logic masterAutoDoze,
	input wire logic autoDozeWrite,
	input wire logic autoDozeValue,
	input wire logic syncLocked,
	input wire logic syncMsgSeen,
	input wire logic linkBusy,
	input wire logic dialled,
	output logic functionsOn,
	output logic rxReady,
	output logic txHold,
	output logic autoDozeMode,
	output logic asleep
);
	typedef struct packed {
		rpsc_pkg::rpsc_state_t state;
		logic [`RPSC_CNT_W-1:0] cnt;
		logic autoDoze;
		logic rxReady;
		logic txHold;
	} rpsc_top_t;
	rpsc_top_t st_reg;
	rpsc_top_t st_next;
	rpsc_sync_if sy ();
	logic pinLow;
	logic isRemote;
	logic isMaster;
	assign sy.rawLevel = sleepCtlN;
	rpsc_pin_sync uSync (
		.clock(clock),
		.rst(rst),
		.sy(sy)
	);
	assign isRemote = (unitRole == `RPSC_ROLE_REMOTE);
	assign isMaster = (unitRole == `RPSC_ROLE_MASTER);
	assign pinLow = ~sy.level;
	always_comb begin
		st_next = st_reg;
		st_next.cnt = st_reg.cnt + `RPSC_CNT_W'(1);
		if (autoDozeWrite && isMaster) begin
			st_next.autoDoze = autoDozeValue;
		end else if (isRemote) begin
			st_next.autoDoze = masterAutoDoze;
		end
		st_next.txHold = 1'h0;
		case (st_reg.state)
			rpsc_pkg::ST_AWAKE: begin
				st_next.rxReady = 1'h1;
				if (!syncLocked) begin
					st_next.state = rpsc_pkg::ST_SEARCH;
					st_next.cnt = '0;
				end else if (isRemote && dozeEnable && pinLow && !linkBusy) begin
					st_next.state = rpsc_pkg::ST_EXT_SLEEP;
					st_next.rxReady = 1'h0;
					st_next.cnt = '0;
				end else if (isRemote && st_reg.autoDoze && !dialled && syncMsgSeen && !linkBusy) begin
					st_next.state = rpsc_pkg::ST_AUTO_SLEEP;
					st_next.rxReady = 1'h0;
					st_next.cnt = '0;
				end
				if (isMaster && st_reg.autoDoze && st_reg.cnt >= RESYNC_CYC && !linkBusy) begin
					st_next.txHold = 1'h1;
				end
				if (isMaster && syncMsgSeen) begin
					st_next.cnt = '0;
				end
			end
			rpsc_pkg::ST_SEARCH: begin
				st_next.rxReady = 1'h1;
				if (syncLocked) begin
					st_next.state = rpsc_pkg::ST_AWAKE;
					st_next.cnt = '0;
				end
			end
			rpsc_pkg::ST_EXT_SLEEP: begin
				st_next.rxReady = 1'h0;
				if (!pinLow || !dozeEnable || st_reg.cnt >= WAKE_TIMER_CYC - `RPSC_CNT_W'(1)) begin
					st_next.state = rpsc_pkg::ST_WAKING;
					st_next.cnt = '0;
				end
			end
			rpsc_pkg::ST_AUTO_SLEEP: begin
				st_next.rxReady = 1'h0;
				if (!st_reg.autoDoze || dialled || st_reg.cnt >= AUTO_SLEEP_CYC - `RPSC_CNT_W'(1)) begin
					st_next.state = rpsc_pkg::ST_WAKING;
					st_next.cnt = '0;
				end
			end
			rpsc_pkg::ST_WAKING: begin
				st_next.rxReady = 1'h0;
				if (st_reg.cnt >= READY_CYC - `RPSC_WAKE_MARGIN) begin
					st_next.state = rpsc_pkg::ST_AWAKE;
					st_next.rxReady = 1'h1;
					st_next.cnt = '0;
				end
			end
			default: begin
				st_next.state = rpsc_pkg::ST_AWAKE;
			end
		endcase
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			st_reg.state <= rpsc_pkg::ST_SEARCH;
			st_reg.cnt <= '0;
			st_reg.autoDoze <= `RPSC_AUTO_DOZE_RST;
			st_reg.rxReady <= 1'h0;
			st_reg.txHold <= 1'h0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign asleep = (st_reg.state == rpsc_pkg::ST_EXT_SLEEP) || (st_reg.state == rpsc_pkg::ST_AUTO_SLEEP);
	assign functionsOn = ~asleep;
	assign rxReady = st_reg.rxReady;
	assign txHold = st_reg.txHold;
	assign autoDozeMode = st_reg.autoDoze;
	chk_role_gate: assert property (@(posedge clock) disable iff (rst)
		$rose(st_reg.state == rpsc_pkg::ST_EXT_SLEEP) |-> $past(isRemote)) else $error("non-remote slept");
	chk_ext_enter: assert property (@(posedge clock) disable iff (rst)
		(st_reg.state == rpsc_pkg::ST_EXT_SLEEP) |-> $past(dozeEnable)) else $error("sleep without enable");
	chk_disabled_wake: assert property (@(posedge clock) disable iff (rst)
		(st_reg.state == rpsc_pkg::ST_EXT_SLEEP && !dozeEnable) |=> (st_reg.state == rpsc_pkg::ST_WAKING)) else $error("disabled doze kept");
	chk_release_wake: assert property (@(posedge clock) disable iff (rst)
		(st_reg.state == rpsc_pkg::ST_EXT_SLEEP && !pinLow) |=> (st_reg.state == rpsc_pkg::ST_WAKING)) else $error("release ignored");
	chk_ready_time: assert property (@(posedge clock) disable iff (rst)
		$fell(st_reg.state == rpsc_pkg::ST_WAKING) |-> (rxReady && st_reg.state == rpsc_pkg::ST_AWAKE)) else $error("ready late");
	chk_ready_cnt: assert property (@(posedge clock) disable iff (rst)
		(st_reg.state == rpsc_pkg::ST_WAKING) |-> (st_reg.cnt < READY_CYC)) else $error("wake over 75 ms");
	chk_search_awake: assert property (@(posedge clock) disable iff (rst)
		(st_reg.state == rpsc_pkg::ST_SEARCH && !syncLocked) |=> (st_reg.state == rpsc_pkg::ST_SEARCH)) else $error("search left");
	chk_busy_defer: assert property (@(posedge clock) disable iff (rst)
		(st_reg.state == rpsc_pkg::ST_AWAKE && linkBusy) |=> !asleep) else $error("slept during transfer");
	chk_dial_awake: assert property (@(posedge clock) disable iff (rst)
		(st_reg.state == rpsc_pkg::ST_AUTO_SLEEP && dialled) |=> !asleep) else $error("dialled unit slept");
	chk_hold_master: assert property (@(posedge clock) disable iff (rst)
		txHold |-> $past(isMaster && st_reg.autoDoze)) else $error("hold without doze");
	chk_reset_doze: assert property (@(posedge clock) $fell(rst) |-> !autoDozeMode) else $error("doze set after reset");
	cov_ext_sleep: cover property (@(posedge clock) disable iff (rst) st_reg.state == rpsc_pkg::ST_EXT_SLEEP);
	cov_auto_sleep: cover property (@(posedge clock) disable iff (rst) st_reg.state == rpsc_pkg::ST_AUTO_SLEEP);
	cov_wake_ready: cover property (@(posedge clock) disable iff (rst) $rose(rxReady));
	cov_tx_hold: cover property (@(posedge clock) disable iff (rst) txHold);
endmodule

// ---- rpsc_rtu_model.sv ----
// Purpose: Terminal unit model driving the sleep control pin
// Assumes: Pin pulled high when released
// Notes: Pin follows the request one falling edge later
`timescale 1ns/1ps
module rpsc_rtu_model (
	input wire logic clock,
	input wire logic wantSleep,
	output logic sleepCtlN
);
	always @(negedge clock) begin
		sleepCtlN <= ~wantSleep;
	end
endmodule

// ---- tb_remote_power_save_control.sv ----
// Purpose: Self-checking bench for the remote power-save controller
// Assumes: Shortened timer parameters
// Notes: Inputs change at the falling edge
`timescale 1ns/1ps
module tb_remote_power_save_control;
	logic clock, rst, dozeEnable, masterAutoDoze, autoDozeWrite, autoDozeValue, syncLocked;
	logic syncMsgSeen, linkBusy, dialled, wantSleep, sleepCtlN;
	logic functionsOn, rxReady, txHold, autoDozeMode, asleep;
	logic [1:0] unitRole;
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	int i;
	rpsc_rtu_model rtu (.clock(clock), .wantSleep(wantSleep), .sleepCtlN(sleepCtlN));
	rpsc_top #(.WAKE_TIMER_CYC(34'hc8), .READY_CYC(34'h14), .AUTO_SLEEP_CYC(34'h64), .RESYNC_CYC(34'h1e)) dut (
		.clock(clock), .rst(rst), .unitRole(unitRole), .dozeEnable(dozeEnable), .sleepCtlN(sleepCtlN),
		.masterAutoDoze(masterAutoDoze), .autoDozeWrite(autoDozeWrite), .autoDozeValue(autoDozeValue),
		.syncLocked(syncLocked), .syncMsgSeen(syncMsgSeen), .linkBusy(linkBusy), .dialled(dialled),
		.functionsOn(functionsOn), .rxReady(rxReady), .txHold(txHold), .autoDozeMode(autoDozeMode),
		.asleep(asleep));
	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end
	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 4000) begin
			num_errors++;
			end_sim();
		end
	end
	task chk(string name, logic seen, logic exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %b seen %b", name, exp, seen);
		end
	endtask
	task tick(int n);
		repeat (n) @(negedge clock);
	endtask
	task pulse_sync;
		syncMsgSeen <= 1'h1;
		tick(1);
		syncMsgSeen <= 1'h0;
	endtask
	task wait_asleep(logic v, int n);
		for (i = 0; i < n && asleep !== v; i++) tick(1);
	endtask
	task t_reset;
		chk("asleep", asleep, 1'h0);
		chk("functionsOn", functionsOn, 1'h1);
		chk("autoDozeMode", autoDozeMode, 1'h0);
		chk("txHold", txHold, 1'h0);
		$display("reset test done");
	endtask
	task t_pin_sleep;
		tick(10);
		wantSleep <= 1'h1;
		tick(8);
		chk("asleep", asleep, 1'h1);
		chk("functionsOn", functionsOn, 1'h0);
		chk("rxReady", rxReady, 1'h0);
		wantSleep <= 1'h0;
		for (i = 0; i < 21 && rxReady !== 1'h1; i++) tick(1);
		chk("rxReady", rxReady, 1'h1);
		$display("pin sleep test done");
	endtask
	task t_timer;
		wantSleep <= 1'h1;
		tick(8);
		chk("asleep", asleep, 1'h1);
		tick(150);
		chk("asleep", asleep, 1'h1);
		wait_asleep(1'h0, 60);
		chk("asleep", asleep, 1'h0);
		wantSleep <= 1'h0;
		tick(40);
		$display("timer test done");
	endtask
	task t_ignored;
		dozeEnable <= 1'h0;
		wantSleep <= 1'h1;
		tick(12);
		chk("asleep", asleep, 1'h0);
		dozeEnable <= 1'h1;
		unitRole <= 2'h0;
		tick(12);
		chk("asleep", asleep, 1'h0);
		wantSleep <= 1'h0;
		autoDozeValue <= 1'h1;
		autoDozeWrite <= 1'h1;
		tick(1);
		autoDozeWrite <= 1'h0;
		tick(2);
		chk("autoDozeMode", autoDozeMode, 1'h1);
		chk("txHold", txHold, 1'h1);
		pulse_sync();
		tick(2);
		chk("txHold", txHold, 1'h0);
		autoDozeValue <= 1'h0;
		autoDozeWrite <= 1'h1;
		tick(1);
		autoDozeWrite <= 1'h0;
		tick(2);
		chk("autoDozeMode", autoDozeMode, 1'h0);
		unitRole <= 2'h1;
		tick(10);
		$display("ignore test done");
	endtask
	task t_auto;
		masterAutoDoze <= 1'h1;
		linkBusy <= 1'h1;
		tick(3);
		chk("autoDozeMode", autoDozeMode, 1'h1);
		syncMsgSeen <= 1'h1;
		tick(1);
		syncMsgSeen <= 1'h0;
		tick(4);
		chk("asleep", asleep, 1'h0);
		linkBusy <= 1'h0;
		tick(2);
		syncMsgSeen <= 1'h1;
		tick(1);
		syncMsgSeen <= 1'h0;
		wait_asleep(1'h1, 5);
		chk("asleep", asleep, 1'h1);
		tick(90);
		chk("asleep", asleep, 1'h1);
		wait_asleep(1'h0, 20);
		chk("asleep", asleep, 1'h0);
		tick(20);
		pulse_sync();
		dialled <= 1'h1;
		tick(2);
		chk("asleep", asleep, 1'h0);
		tick(20);
		pulse_sync();
		tick(2);
		chk("asleep", asleep, 1'h0);
		dialled <= 1'h0;
		masterAutoDoze <= 1'h0;
		tick(120);
		$display("auto doze test done");
	endtask
	task t_search;
		syncLocked <= 1'h0;
		wantSleep <= 1'h1;
		tick(12);
		chk("asleep", asleep, 1'h0);
		syncLocked <= 1'h1;
		tick(8);
		chk("asleep", asleep, 1'h1);
		wantSleep <= 1'h0;
		tick(30);
		chk("rxReady", rxReady, 1'h1);
		$display("search test done");
	endtask
	initial begin
		rst = 1'h1;
		unitRole = 2'h1;
		dozeEnable = 1'h1;
		{masterAutoDoze, autoDozeWrite, autoDozeValue, syncMsgSeen, linkBusy, dialled, wantSleep} = 7'h00;
		syncLocked = 1'h1;
		tick(2);
		rst = 1'h0;
		tick(1);
		t_reset();
		t_pin_sleep();
		t_timer();
		t_ignored();
		t_search();
		t_auto();
		end_sim();
	end
endmodule
